/* File: src/swc_pkg.sv */
package swc_pkg;
   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'h0;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h1;
   localparam logic [3:0] OFS_IRQ_FLAG = 4'h2;
   localparam logic [3:0] OFS_CORE_FLAGS = 4'h3;
   localparam logic [3:0] OFS_WDT_CONTROL = 4'h4;
   // field positions
   localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
   localparam int BIT_TIMED_OUT_N = 4;
   localparam int BIT_POWERED_DOWN_N = 3;
   localparam int BIT_WDT_SW_EN = 0;
   localparam int WDT_SEL_LSB = 1;
   // reset values
   localparam logic [4:0] WDT_SEL_RST = 5'h0B;
   localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
   // watchdog configuration codes
   localparam logic [1:0] WDT_CFG_ALWAYS = 2'h3;
   localparam logic [1:0] WDT_CFG_OFF_SLEEP = 2'h2;
   localparam logic [1:0] WDT_CFG_SOFTWARE = 2'h1;
   // watchdog period select
   localparam int WDT_CNT_W = 24;
   localparam logic [4:0] WDT_SEL_MAX = 5'h12;
   localparam logic [23:0] WDT_BASE_TICKS = 24'h000020;
   // oscillator modes and start-up timer
   localparam logic [1:0] OSC_MODE_RC = 2'h0;
   localparam logic [1:0] OSC_MODE_CRYSTAL = 2'h1;
   localparam logic [1:0] OSC_MODE_HIGH_SPEED = 2'h2;
   localparam logic [1:0] OSC_MODE_LOW_POWER = 2'h3;
   localparam int OST_W = 11;
   localparam logic [10:0] OST_PERIODS = 11'h400;
   // interrupt vector and pins
   localparam int PC_W = 15;
   localparam logic [14:0] ISR_VECTOR = 15'h0004;
   localparam int IO_W = 8;
   localparam int IRQ_N = 8;

   typedef enum logic [3:0] {
      SWC_ST_RESET = 4'b0001,
      SWC_ST_RUN = 4'b0010,
      SWC_ST_SLEEP = 4'b0100,
      SWC_ST_OST = 4'b1000
   } swc_state_t;
endpackage : swc_pkg

/* File: src/swc_sleep_wake.sv */
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module swc_sleep_wake
   import swc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // instruction sequencer
   input wire logic sleep_instr,
   input wire logic clear_watchdog_instr,
   output logic core_clk_en,
   output logic prefetch_next,
   output logic wake_pulse,
   output logic isr_branch,
   output logic [PC_W-1:0] isr_vector_addr,
   output logic device_reset_n,
   output logic watchdog_reset,
   // reset sources and configuration
   input wire logic external_reset_pin_n,
   input wire logic external_reset_enable,
   input wire logic brownout_reset,
   input wire logic brownout_enable,
   input wire logic power_on_reset,
   input wire logic regulator_cap_charged,
   input wire logic regulator_cap_pin_select,
   input wire logic [1:0] osc_mode,
   input wire logic [1:0] watchdog_config,
   input wire logic converter_dedicated_rc_clock,
   // time bases
   input wire logic low_freq_tick,
   input wire logic osc_period_tick,
   // interrupt events
   input wire logic [IRQ_N-1:0] irq_event,
   output logic wake_request,
   // oscillator and peripheral run enables
   output logic low_freq_internal_osc_en,
   output logic secondary_osc_en,
   output logic converter_run_en,
   output logic cap_sense_osc_en,
   // pins and watchdog counter
   input wire logic [IO_W-1:0] io_out_core,
   input wire logic [IO_W-1:0] io_oe_core,
   output logic [IO_W-1:0] io_out_pad,
   output logic [IO_W-1:0] io_oe_pad,
   output logic port_f_bit0_is_cap,
   output logic [WDT_CNT_W-1:0] watchdog_counter
);

   // all block state in one record: one comb process fills the copy, one flop bank holds it
   typedef struct packed {
      swc_state_t st;
      logic [IRQ_N-1:0] flag;
      logic [IRQ_N-1:0] ien;
      logic global_irq_enable;
      logic powered_down_n_flag;
      logic timed_out_n_flag;
      logic [WDT_CNT_W-1:0] wdt_cnt;
      logic [4:0] wdt_sel;
      logic wdt_sw_en;
      logic [OST_W-1:0] ost_cnt;
      logic woke_by_irq;
      logic [IO_W-1:0] hold_out;
      logic [IO_W-1:0] hold_oe;
      logic [DATA_W-1:0] rdata;
      logic wake_pulse;
      logic isr_branch;
      logic prefetch;
      logic wdt_reset;
   } swc_regs_t;

   swc_regs_t r_reg;
   swc_regs_t r_next;
   // combinational helpers shared by the next-state and output logic
   logic hard_reset;
   logic wdt_active;
   logic wdt_hit;
   logic asleep;
   logic crystal_mode;

   // watchdog period: 32 ticks doubled per select step, reserved codes fall back to the minimum
   // the limit is a shift, not a table, so every select code costs the same logic;
   // the compare is >= so a counter left above a shortened limit still fires at once
   function automatic logic wdt_expired(input logic [WDT_CNT_W-1:0] cnt, input logic [4:0] sel);
      logic [WDT_CNT_W-1:0] limit;
      limit = (sel > WDT_SEL_MAX) ? WDT_BASE_TICKS : (WDT_BASE_TICKS << sel);
      return cnt >= (limit - WDT_CNT_W'(1));
   endfunction : wdt_expired

   // core-flags byte as software sees it
   // both status bits read active low, every other bit reads zero
   function automatic logic [DATA_W-1:0] core_flags_byte(input logic to_n, input logic pd_n);
      logic [DATA_W-1:0] v;
      v = '0;
      v[BIT_TIMED_OUT_N] = to_n;
      v[BIT_POWERED_DOWN_N] = pd_n;
      return v;
   endfunction : core_flags_byte

   // reset sources behave identically awake or asleep, so no state term here
   // these levels are taken as already synchronous; a glitch on the pin therefore
   // reaches the state machine unfiltered, so filtering belongs in the pad ring
   assign hard_reset = power_on_reset
      | (external_reset_enable & ~external_reset_pin_n)
      | (brownout_enable & brownout_reset);

   // purely combinational so a wake works with the core clock stopped
   // the global enable is left out on purpose: it only chooses where execution resumes
   assign wake_request = |(r_reg.flag & r_reg.ien);

   assign asleep = (r_reg.st == SWC_ST_SLEEP);
   assign crystal_mode = (osc_mode == OSC_MODE_CRYSTAL) | (osc_mode == OSC_MODE_HIGH_SPEED)
      | (osc_mode == OSC_MODE_LOW_POWER);

   // watchdog runs per configuration; off-in-sleep mode stops it only while asleep
   // a disabled watchdog is held at zero below, so enabling it always starts a full period
   always_comb
   begin
      case (watchdog_config)
         WDT_CFG_ALWAYS: wdt_active = 1'b1;
         WDT_CFG_OFF_SLEEP: wdt_active = ~asleep;
         WDT_CFG_SOFTWARE: wdt_active = r_reg.wdt_sw_en;
         default: wdt_active = 1'b0;
      endcase
   end

   assign wdt_hit = wdt_active & low_freq_tick & wdt_expired(r_reg.wdt_cnt, r_reg.wdt_sel);

   // next-state logic
   // every field starts from its registered value; the one-cycle pulses and the read
   // data start from zero so that nothing stands longer than the cycle it belongs to
   always_comb
   begin
      r_next = r_reg;
      r_next.wake_pulse = 1'b0;
      r_next.isr_branch = 1'b0;
      r_next.prefetch = 1'b0;
      r_next.wdt_reset = 1'b0;
      r_next.rdata = '0;

      // register reads answer one cycle later; unmapped offsets read zero
      // the read path takes no state change, so reads never disturb a flag
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_INTERRUPT_CONTROL: r_next.rdata = {r_reg.global_irq_enable, 7'h00};
            OFS_IRQ_ENABLE: r_next.rdata = r_reg.ien;
            OFS_IRQ_FLAG: r_next.rdata = r_reg.flag;
            OFS_CORE_FLAGS: r_next.rdata = core_flags_byte(r_reg.timed_out_n_flag, r_reg.powered_down_n_flag);
            OFS_WDT_CONTROL: r_next.rdata = {2'h0, r_reg.wdt_sel, r_reg.wdt_sw_en};
            default: r_next.rdata = '0;
         endcase
      end

      // register writes; core flags are read-only
      if (reg_wr)
      begin
         case (reg_addr)
            OFS_INTERRUPT_CONTROL: r_next.global_irq_enable = reg_wdata[BIT_GLOBAL_IRQ_ENABLE];
            OFS_IRQ_ENABLE: r_next.ien = reg_wdata;
            OFS_IRQ_FLAG: r_next.flag = reg_wdata;
            OFS_WDT_CONTROL:
            begin
               r_next.wdt_sel = reg_wdata[WDT_SEL_LSB +: 5];
               r_next.wdt_sw_en = reg_wdata[BIT_WDT_SW_EN];
            end
            default: r_next.flag = r_next.flag;
         endcase
      end

      // events set flags whatever the enables; a set beats a clear in the same cycle
      r_next.flag = r_next.flag | irq_event;

      // watchdog counting, cleared while disabled or by the clear instruction
      if (!wdt_active || clear_watchdog_instr)
         r_next.wdt_cnt = '0;
      else if (low_freq_tick)
         r_next.wdt_cnt = wdt_hit ? '0 : r_reg.wdt_cnt + WDT_CNT_W'(1);

      if (clear_watchdog_instr)
      begin
         r_next.timed_out_n_flag = 1'b1;
         r_next.powered_down_n_flag = 1'b1;
      end

      case (r_reg.st)
         SWC_ST_RESET:
         begin
            // held until the capacitor is charged and every source has let go
            // the watchdog stays cleared here, as after any reset
            r_next.wdt_cnt = '0;
            if (regulator_cap_charged && !hard_reset)
               r_next.st = SWC_ST_RUN;
         end
         SWC_ST_RUN:
         begin
            if (wdt_hit)
            begin
               // awake timeout resets the device
               r_next.st = SWC_ST_RESET;
               r_next.wdt_reset = 1'b1;
               r_next.timed_out_n_flag = 1'b0;
               r_next.powered_down_n_flag = 1'b1;
            end
            else if (sleep_instr && !wake_request)
            begin
               r_next.st = SWC_ST_SLEEP;
               r_next.wdt_cnt = '0;
               r_next.powered_down_n_flag = 1'b0;
               r_next.timed_out_n_flag = 1'b1;
               r_next.prefetch = 1'b1;
               r_next.hold_out = io_out_core;
               r_next.hold_oe = io_oe_core;
               r_next.woke_by_irq = 1'b0;
            end
         end
         SWC_ST_SLEEP:
         begin
            // a flag raised during or after the instruction wakes at once
            // a watchdog hit in the same cycle takes precedence for the flags and the branch
            if (wake_request || wdt_hit)
            begin
               r_next.wdt_cnt = '0;
               r_next.woke_by_irq = wake_request & ~wdt_hit;
               if (wdt_hit)
               begin
                  // no reset here, only a wake with the flags marking the timeout
                  r_next.timed_out_n_flag = 1'b0;
                  r_next.powered_down_n_flag = 1'b0;
               end
               if (crystal_mode)
               begin
                  r_next.st = SWC_ST_OST;
                  r_next.ost_cnt = '0;
               end
               else
               begin
                  r_next.st = SWC_ST_RUN;
                  r_next.wake_pulse = 1'b1;
                  r_next.isr_branch = wake_request & ~wdt_hit & r_reg.global_irq_enable;
               end
            end
         end
         SWC_ST_OST:
         begin
            // the watchdog stays clear until the start-up timer is done
            // osc_period_tick comes from the oscillator being started, so this waits on it alone
            r_next.wdt_cnt = '0;
            if (osc_period_tick)
            begin
               if (r_reg.ost_cnt == OST_PERIODS - OST_W'(1))
               begin
                  r_next.st = SWC_ST_RUN;
                  r_next.wake_pulse = 1'b1;
                  r_next.isr_branch = r_reg.woke_by_irq & r_reg.global_irq_enable;
               end
               else
                  r_next.ost_cnt = r_reg.ost_cnt + OST_W'(1);
            end
         end
         default: r_next.st = SWC_ST_RESET;
      endcase

      // pin, brown-out and power-on events win over everything, asleep or not
      // placed last so no earlier branch can override it; the status flags survive a
      // pin or brown-out reset so software can still tell what the core was doing
      if (hard_reset || !regulator_cap_charged)
      begin
         r_next.st = SWC_ST_RESET;
         r_next.wdt_cnt = '0;
         r_next.wake_pulse = 1'b0;
         r_next.isr_branch = 1'b0;
         r_next.prefetch = 1'b0;
         r_next.ien = IRQ_ENABLE_RST;
         r_next.global_irq_enable = 1'b0;
         r_next.wdt_sel = WDT_SEL_RST;
         r_next.wdt_sw_en = 1'b0;
         if (power_on_reset)
         begin
            r_next.timed_out_n_flag = 1'b1;
            r_next.powered_down_n_flag = 1'b1;
         end
      end
   end

   // state register
   // only constants in the reset branch; the configuration reset values come from the package
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
         r_reg.st <= SWC_ST_RESET;
         r_reg.timed_out_n_flag <= 1'b1;
         r_reg.powered_down_n_flag <= 1'b1;
         r_reg.wdt_sel <= WDT_SEL_RST;
         r_reg.ien <= IRQ_ENABLE_RST;
      end
      else
         r_reg <= r_next;
   end

   // sequencer side
   // sequencer outputs come from flip-flops or from compares on the registered state (core_clk_en, device_reset_n), so they carry no glitches
   // into the clock gate even while the state is changing
   assign core_clk_en = (r_reg.st == SWC_ST_RUN);
   assign device_reset_n = (r_reg.st != SWC_ST_RESET);
   assign prefetch_next = r_reg.prefetch;
   assign wake_pulse = r_reg.wake_pulse;
   assign isr_branch = r_reg.isr_branch;
   assign isr_vector_addr = ISR_VECTOR;
   assign watchdog_reset = r_reg.wdt_reset;
   assign reg_rdata = r_reg.rdata;
   assign watchdog_counter = r_reg.wdt_cnt;

   // slow clocks never stop; the converter keeps its own clock only when it runs from it
   // the slow oscillator also times the watchdog, so gating it would break watchdog wake-up
   assign low_freq_internal_osc_en = 1'b1;
   assign secondary_osc_en = 1'b1;
   assign converter_run_en = ~asleep | converter_dedicated_rc_clock;
   assign cap_sense_osc_en = 1'b1;

   // pins: frozen copy while asleep and in the start-up wait, live otherwise (reset state included); bit 0 yields to the cap
   // the copy is also kept through the start-up wait, because the core logic that
   // drives the live values is still unclocked then; the cap overrides both cases
   assign port_f_bit0_is_cap = ~regulator_cap_pin_select;
   always_comb
   begin
      if (r_reg.st == SWC_ST_SLEEP || r_reg.st == SWC_ST_OST)
      begin
         io_out_pad = r_reg.hold_out;
         io_oe_pad = r_reg.hold_oe;
      end
      else
      begin
         io_out_pad = io_out_core;
         io_oe_pad = io_oe_core;
      end
      if (port_f_bit0_is_cap)
      begin
         io_out_pad[0] = 1'b0;
         io_oe_pad[0] = 1'b0;
      end
   end

endmodule : swc_sleep_wake

/* File: dv/swc_far_model.sv */
`timescale 1ns/1ps
module swc_far_model
   import swc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic core_clk_en,
   // time bases and pin drive
   output logic low_freq_tick,
   output logic osc_period_tick,
   output logic [IO_W-1:0] io_out_core,
   output logic [IO_W-1:0] io_oe_core
);
   logic [1:0] div_reg;
   // slow tick every fourth cycle keeps watchdog periods short
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         div_reg <= 2'h0;
         io_out_core <= 8'h00;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         if (core_clk_en)
            io_out_core <= io_out_core + 8'h01; // a stopped core moves no pin
      end
   // slow oscillator runs whatever the core does
   assign low_freq_tick = (div_reg == 2'h3);
   assign osc_period_tick = 1'b1; // main oscillator period equals core period
   assign io_oe_core = {io_out_core[3:0], io_out_core[7:4]};
endmodule : swc_far_model

/* File: dv/swc_sleep_wake_sva.sv */
`timescale 1ns/1ps
module swc_sleep_wake_chk
   import swc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // watched ports
   input wire logic sleep_instr,
   input wire logic core_clk_en,
   input wire logic prefetch_next,
   input wire logic wake_pulse,
   input wire logic isr_branch,
   input wire logic [PC_W-1:0] isr_vector_addr,
   input wire logic device_reset_n,
   input wire logic watchdog_reset,
   input wire logic brownout_reset,
   input wire logic brownout_enable,
   input wire logic power_on_reset,
   input wire logic regulator_cap_charged,
   input wire logic regulator_cap_pin_select,
   input wire logic [1:0] osc_mode,
   input wire logic wake_request,
   input wire logic [IO_W-1:0] io_out_pad,
   input wire logic [IO_W-1:0] io_oe_pad,
   input wire logic port_f_bit0_is_cap,
   input wire logic [WDT_CNT_W-1:0] watchdog_counter
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // sleep entry, no-op case and their side effects
   property p_entry; sleep_instr && core_clk_en && !wake_request |=> !core_clk_en && prefetch_next; endproperty
   a_entry: assert property (p_entry) else $error("entry missed");
   property p_noop; sleep_instr && core_clk_en && wake_request |=> core_clk_en && !prefetch_next; endproperty
   a_noop: assert property (p_noop) else $error("pending irq not a no-op");
   property p_only; prefetch_next |-> $past(sleep_instr) && $past(core_clk_en); endproperty
   a_only: assert property (p_only) else $error("entry without instruction");
   property p_wdclr; prefetch_next || wake_pulse |-> watchdog_counter == 24'h000000; endproperty
   a_wdclr: assert property (p_wdclr) else $error("watchdog not cleared");
   // wake-up without oscillator start-up takes one cycle
   property p_wake; wake_request && !core_clk_en && device_reset_n && osc_mode == OSC_MODE_RC
      |=> core_clk_en && wake_pulse; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_isr; isr_branch |-> wake_pulse && isr_vector_addr == ISR_VECTOR; endproperty
   a_isr: assert property (p_isr) else $error("bad branch");
   property p_pins; !core_clk_en && device_reset_n |-> $stable(io_out_pad) && $stable(io_oe_pad); endproperty
   a_pins: assert property (p_pins) else $error("pins moved asleep");
   property p_cap; port_f_bit0_is_cap == !regulator_cap_pin_select && !(port_f_bit0_is_cap && io_oe_pad[0]); endproperty
   a_cap: assert property (p_cap) else $error("cap pin select");
   property p_rst; power_on_reset || (brownout_reset && brownout_enable) || !regulator_cap_charged
      |=> !device_reset_n; endproperty
   a_rst: assert property (p_rst) else $error("reset not held");
   c_entry: cover property (prefetch_next);
   c_isr: cover property (isr_branch);
   c_wdrst: cover property (watchdog_reset);
endmodule : swc_sleep_wake_chk

bind swc_sleep_wake swc_sleep_wake_chk u_chk (.core_clk, .nrst, .sleep_instr, .core_clk_en, .prefetch_next,
   .wake_pulse, .isr_branch, .isr_vector_addr, .device_reset_n, .watchdog_reset, .brownout_reset, .brownout_enable,
   .power_on_reset, .regulator_cap_charged, .regulator_cap_pin_select, .osc_mode, .wake_request, .io_out_pad,
   .io_oe_pad, .port_f_bit0_is_cap, .watchdog_counter);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import swc_pkg::*;
;
   logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_instr = 1'b0, clr_wd = 1'b0;
   logic brownout_reset = 1'b0, brownout_enable = 1'b0, regulator_cap_charged = 1'b0, cap_sel = 1'b0;
   logic conv_rc = 1'b1, ext_rst_n = 1'b1, ext_en = 1'b1, por = 1'b0, lf_en, sec_en, conv_run, sense_en;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
   logic [1:0] osc_mode = OSC_MODE_RC, watchdog_config = 2'h0;
   logic [IRQ_N-1:0] irq_event = 8'h00;
   logic core_clk_en, wake_pulse, isr_branch, device_reset_n, watchdog_reset, lf_tick, osc_tick, f0_cap;
   logic [IO_W-1:0] io_out_core, io_oe_core;
   int miscompares = 0, n_checks = 0, cycles = 0;

   swc_sleep_wake dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr,
      .clear_watchdog_instr(clr_wd), .core_clk_en, .prefetch_next(), .wake_pulse, .isr_branch, .isr_vector_addr(),
      .device_reset_n, .watchdog_reset, .external_reset_pin_n(ext_rst_n), .external_reset_enable(ext_en),
      .brownout_reset, .brownout_enable, .power_on_reset(por), .regulator_cap_charged,
      .regulator_cap_pin_select(cap_sel), .osc_mode, .watchdog_config, .converter_dedicated_rc_clock(conv_rc),
      .low_freq_tick(lf_tick), .osc_period_tick(osc_tick), .irq_event, .wake_request(),
      .low_freq_internal_osc_en(lf_en), .secondary_osc_en(sec_en), .converter_run_en(conv_run),
      .cap_sense_osc_en(sense_en), .io_out_core, .io_oe_core, .io_out_pad(), .io_oe_pad(),
      .port_f_bit0_is_cap(f0_cap), .watchdog_counter());
   swc_far_model u_far (.core_clk, .nrst, .core_clk_en, .low_freq_tick(lf_tick), .osc_period_tick(osc_tick),
      .io_out_core, .io_oe_core);

   always #50 core_clk = ~core_clk;
   // hang guard, well above the longest expected run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end

   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data is looked at only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata === e, "read data");
   endtask : rd
   // sleep and interrupt pulses may share an edge for the late-interrupt case
   task automatic pulse(input logic s, input logic [7:0] q, input logic c);
      @(posedge core_clk);
      sleep_instr <= s;
      irq_event <= q;
      clr_wd <= c;
      @(posedge core_clk);
      sleep_instr <= 1'b0;
      irq_event <= 8'h00;
      clr_wd <= 1'b0;
      #1;
   endtask : pulse
   task automatic wrun(output int n);
      n = 0;
      while (core_clk_en !== 1'b1 && n < 3000)
      begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask : wrun

   task automatic t_init;
      tick(3);
      chk(device_reset_n === 1'b0, "held while cap charges");
      regulator_cap_charged <= 1'b1;
      tick(3);
      chk(device_reset_n === 1'b1, "reset release");
      rd(OFS_INTERRUPT_CONTROL, 8'h00);
      rd(OFS_WDT_CONTROL, {2'h0, WDT_SEL_RST, 1'b0});
      wr(OFS_CORE_FLAGS, 8'h00);
      rd(OFS_CORE_FLAGS, 8'h18);
      rd(4'hF, 8'h00);
   endtask : t_init
   task automatic t_noop;
      wr(OFS_IRQ_ENABLE, 8'h01);
      pulse(1'b0, 8'h01, 1'b0);
      pulse(1'b1, 8'h00, 1'b0);
      chk(core_clk_en === 1'b1, "sleep not skipped");
      rd(OFS_CORE_FLAGS, 8'h18);
      wr(OFS_IRQ_FLAG, 8'h00);
   endtask : t_noop
   task automatic t_irq(input logic g);
      int n;
      conv_rc <= g;
      wr(OFS_IRQ_ENABLE, 8'h02);
      wr(OFS_INTERRUPT_CONTROL, {g, 7'h00});
      pulse(1'b1, 8'h00, 1'b0); // sequencer issues nothing but the prefetched no-op
      pulse(1'b0, 8'h04, 1'b0);
      tick(4);
      chk(core_clk_en === 1'b0, "masked source woke");
      chk(lf_en === 1'b1 && sec_en === 1'b1 && sense_en === 1'b1, "slow clocks stopped");
      chk(conv_run === g, "converter run asleep");
      pulse(1'b0, 8'h02, 1'b0);
      wrun(n);
      chk(wake_pulse === 1'b1 && isr_branch === g, "wake kind");
      chk(conv_run === 1'b1, "converter off awake");
      rd(OFS_IRQ_FLAG, 8'h06);
      rd(OFS_CORE_FLAGS, 8'h10);
      wr(OFS_IRQ_FLAG, 8'h00);
   endtask : t_irq
   task automatic t_ost(input logic [1:0] m);
      int n;
      osc_mode <= m;
      pulse(1'b1, 8'h02, 1'b0);
      chk(core_clk_en === 1'b0, "late irq entry");
      wrun(n);
      chk(n >= 1024 && n <= 1030, "start-up delay");
      chk(wake_pulse === 1'b1 && isr_branch === 1'b1, "crystal wake kind");
      rd(OFS_CORE_FLAGS, 8'h10);
      wr(OFS_IRQ_FLAG, 8'h00);
      osc_mode <= OSC_MODE_RC;
   endtask : t_ost
   task automatic t_wdt;
      int n;
      wr(OFS_WDT_CONTROL, 8'h00);
      watchdog_config <= WDT_CFG_ALWAYS;
      pulse(1'b1, 8'h00, 1'b0);
      wrun(n);
      chk(device_reset_n === 1'b1 && wake_pulse === 1'b1 && isr_branch === 1'b0, "watchdog wake");
      rd(OFS_CORE_FLAGS, 8'h00);
      pulse(1'b0, 8'h00, 1'b1);
      rd(OFS_CORE_FLAGS, 8'h18);
      n = 0;
      while (watchdog_reset !== 1'b1 && n < 1000)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(watchdog_reset === 1'b1, "awake timeout");
      tick(3);
      rd(OFS_CORE_FLAGS, 8'h08);
      wr(OFS_IRQ_ENABLE, 8'h02);
      watchdog_config <= WDT_CFG_OFF_SLEEP;
      pulse(1'b1, 8'h00, 1'b0);
      tick(300);
      chk(core_clk_en === 1'b0, "watchdog active asleep");
      watchdog_config <= 2'h0;
      pulse(1'b0, 8'h02, 1'b0);
      wrun(n);
      chk(wake_pulse === 1'b1, "irq wake");
      wr(OFS_IRQ_FLAG, 8'h00);
      // software-enabled watchdog times out asleep as well
      wr(OFS_WDT_CONTROL, 8'h01);
      watchdog_config <= WDT_CFG_SOFTWARE;
      pulse(1'b1, 8'h00, 1'b0);
      wrun(n);
      chk(n > 100 && wake_pulse === 1'b1 && isr_branch === 1'b0, "software watchdog wake");
      watchdog_config <= 2'h0;
   endtask : t_wdt
   task automatic t_bor;
      cap_sel <= 1'b1;
      pulse(1'b1, 8'h00, 1'b0);
      brownout_enable <= 1'b1;
      brownout_reset <= 1'b1;
      tick(2);
      chk(device_reset_n === 1'b0 && f0_cap === 1'b0, "brown-out wake");
      brownout_reset <= 1'b0;
      tick(3);
      chk(device_reset_n === 1'b1, "brown-out release");
      rd(OFS_CORE_FLAGS, 8'h10);
      // a disabled pin is ignored asleep, an enabled one resets; power-on sets both flags
      ext_en <= 1'b0;
      pulse(1'b1, 8'h00, 1'b0);
      ext_rst_n <= 1'b0;
      tick(3);
      chk(core_clk_en === 1'b0 && device_reset_n === 1'b1, "disabled pin acted");
      ext_en <= 1'b1;
      tick(2);
      chk(device_reset_n === 1'b0, "pin wake");
      ext_rst_n <= 1'b1;
      tick(3);
      rd(OFS_CORE_FLAGS, 8'h10);
      pulse(1'b1, 8'h00, 1'b0);
      por <= 1'b1;
      tick(2);
      chk(device_reset_n === 1'b0, "power-on wake");
      por <= 1'b0;
      tick(3);
      rd(OFS_CORE_FLAGS, 8'h18);
   endtask : t_bor

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   initial
   begin
      tick(12);
      nrst <= 1'b1;
      t_init();
      t_noop();
      t_irq(1'b0);
      t_irq(1'b1);
      t_ost(OSC_MODE_CRYSTAL);
      t_ost(OSC_MODE_HIGH_SPEED);
      t_ost(OSC_MODE_LOW_POWER);
      t_wdt();
      t_bor();
      stop_test();
   end
endmodule : tb_top
